// >>> design/ctx_core_seq.sv
// instruction sequencer: fetch, operand collection, clock counting and branch timing
// Behaviour
// [RQ1] decode opcodes exactly as the classic instruction set
// [RQ2] count latency in core clocks only
// [RQ3] taken conditional branch costs one extra clock
// [RQ4] accumulator with working register: one byte, one clock
// [RQ5] accumulator with direct or immediate: two clocks
// [RQ6] indirect pointer operand: one byte, two clocks
// [RQ7] accumulator into direct byte: two bytes, two clocks
// [RQ8] immediate into direct byte logic: three clocks
// [RQ9] direct or immediate to direct move: three clocks
// [RQ10] accumulator to indirect RAM: one byte, two clocks
// [RQ11] accumulator-only operations take one clock
// [RQ12] working register to or from direct: two clocks
// [RQ13] working register store to direct: two bytes
// [RQ14] breakpoints, halt, run, step, state access
// [RQ15] debug uses no user resources, non-intrusive
// [RQ16] programming and debug go over two-wire link
// [RQ17] relative offset signed, from next instruction
// [RQ18] direct below 0x80 is RAM, else SFR
// [RQ19] cycles from opcode class, extra after resolve
`timescale 1ns/1ns
module ctx_core_seq
  import ctx_pkg::*;
(
  input logic CLK_SYS,
  input logic RST,
  output logic [15:0] PM_ADDR,
  input logic [7:0] PM_DATA,
  input logic BR_COND,
  input logic [15:0] EXT_TARGET,
  output logic [7:0] INSN_OPCODE,
  output logic INSN_START,
  output logic INSN_DONE,
  output logic [3:0] INSN_CYCLES,
  output logic [1:0] INSN_BYTES,
  output logic BR_TAKEN,
  output logic [2:0] FLAG_MASK,
  output logic [7:0] DIR_ADDR,
  output logic DIR_SFR,
  output logic DIR_VALID,
  input logic DBG_HALT_REQ,
  input logic DBG_RUN_REQ,
  input logic DBG_STEP_REQ,
  input logic DBG_BP_EN,
  input logic [15:0] DBG_BP_ADDR,
  input logic DBG_ACC_REQ,
  output logic DBG_HALTED,
  output logic DBG_ACC_GNT
);
  typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_TAKEN} ctx_state_t;

  // ==========================================================
  // state
  ctx_state_t st_q;
  ctx_state_t st_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [1:0] len_q;
  logic [3:0] base_q;
  logic [3:0] cyc_q;
  logic [1:0] idx_q;
  logic cond_q;
  ctx_jump_t jump_q;
  logic dir_q;
  logic [7:0] opnd_q;
  logic [7:0] last_q;

  // ==========================================================
  // decode and debug
  logic [1:0] dec_len;
  logic [3:0] dec_cyc;
  logic dec_cond;
  ctx_jump_t dec_jump;
  logic [2:0] dec_flags;
  logic dec_dir;
  logic go;
  logic start;
  logic capture;
  logic last;
  logic taken_now;
  logic done_now;
  logic [3:0] total;

  ctx_op_decode u_dec (
    .op(PM_DATA),
    .len(dec_len),
    .cyc(dec_cyc),
    .cond(dec_cond),
    .jump(dec_jump),
    .flags(dec_flags),
    .has_dir(dec_dir)
  );

  ctx_dbg_ctrl u_dbg (
    .clk(CLK_SYS),
    .rst(RST),
    .halt_req(DBG_HALT_REQ),
    .run_req(DBG_RUN_REQ),
    .step_req(DBG_STEP_REQ),
    .bp_en(DBG_BP_EN),
    .bp_addr(DBG_BP_ADDR),
    .acc_req(DBG_ACC_REQ),
    .at_boundary(st_q == ST_FETCH),
    .pc(pc_q),
    .insn_start(start),
    .go(go),
    .halted_q(DBG_HALTED),
    .acc_gnt_q(DBG_ACC_GNT)
  );

  // ==========================================================
  // cycle bookkeeping; one clock is one instruction step, no machine cycles
  assign start = st_q == ST_FETCH && go;
  assign capture = st_q == ST_EXEC && idx_q < len_q;
  assign last = st_q == ST_EXEC && cyc_q + CYC_1 == base_q; // RQ2
  assign taken_now = last && cond_q && BR_COND; // RQ19
  assign done_now = (start && dec_cyc == CYC_1) || (last && !taken_now) || st_q == ST_TAKEN;
  assign total = cyc_q + CYC_1;

  // ==========================================================
  // next state and program counter
  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    case (st_q)
      ST_FETCH: begin
        if (start) begin
          pc_d = pc_q + 16'h0001;
          st_d = (dec_cyc == CYC_1) ? ST_FETCH : ST_EXEC; // RQ4 RQ11
        end
      end
      ST_EXEC: begin
        if (capture) begin
          pc_d = pc_q + 16'h0001;
        end
        if (last) begin
          st_d = taken_now ? ST_TAKEN : ST_FETCH; // RQ3
          if (!cond_q) begin
            case (jump_q)
              JK_REL: pc_d = ctx_rel_target(pc_q, last_q); // RQ17
              JK_ABS11: pc_d = {pc_q[15:11], INSN_OPCODE[7:5], opnd_q};
              JK_ABS16: pc_d = {opnd_q, last_q};
              JK_EXT: pc_d = EXT_TARGET;
              default: pc_d = pc_d;
            endcase
          end
        end
      end
      ST_TAKEN: begin
        // the offset is added only once the condition has been resolved
        pc_d = ctx_rel_target(pc_q, last_q); // RQ17 RQ19
        st_d = ST_FETCH;
      end
      default: st_d = ST_FETCH;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q <= ST_FETCH;
      pc_q <= PC_RESET;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
    end
  end

  // ==========================================================
  // per-instruction class latched at fetch
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      len_q <= LEN_1;
      base_q <= CYC_1;
      cond_q <= 1'b0;
      jump_q <= JK_NONE;
      dir_q <= 1'b0;
      INSN_OPCODE <= 8'h00;
      FLAG_MASK <= 3'h0;
    end else if (start) begin
      len_q <= dec_len; // RQ19
      base_q <= dec_cyc; // RQ19
      cond_q <= dec_cond;
      jump_q <= dec_jump;
      dir_q <= dec_dir;
      INSN_OPCODE <= PM_DATA; // RQ1
      FLAG_MASK <= dec_flags; // RQ1
    end
  end

  // clocks elapsed and bytes consumed inside the instruction
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cyc_q <= 4'h0;
      idx_q <= 2'h0;
    end else if (start) begin
      cyc_q <= CYC_1;
      idx_q <= LEN_1;
    end else if (st_q != ST_FETCH) begin
      cyc_q <= total; // RQ2
      if (capture) begin
        idx_q <= idx_q + LEN_1;
      end
    end
  end

  // ==========================================================
  // operand bytes; the offset of a branch is always its final byte
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      opnd_q <= 8'h00;
      last_q <= 8'h00;
    end else if (capture) begin
      last_q <= PM_DATA;
      if (idx_q == LEN_1) begin
        opnd_q <= PM_DATA;
      end
    end
  end

  // direct operand space select for the data path
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DIR_ADDR <= 8'h00;
      DIR_SFR <= 1'b0;
      DIR_VALID <= 1'b0;
    end else if (start) begin
      DIR_VALID <= 1'b0;
    end else if (capture && idx_q == LEN_1 && dir_q) begin
      DIR_ADDR <= PM_DATA;
      DIR_SFR <= PM_DATA >= SFR_BASE; // RQ18
      DIR_VALID <= 1'b1;
    end
  end

  // ==========================================================
  // completion reporting, registered so every output is a flop
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      INSN_START <= 1'b0;
      INSN_DONE <= 1'b0;
      INSN_CYCLES <= 4'h0;
      INSN_BYTES <= 2'h0;
      BR_TAKEN <= 1'b0;
    end else begin
      INSN_START <= start;
      INSN_DONE <= done_now;
      if (done_now) begin
        INSN_CYCLES <= start ? CYC_1 : total; // RQ2
        INSN_BYTES <= start ? dec_len : len_q;
        BR_TAKEN <= st_q == ST_TAKEN; // RQ3
      end
    end
  end

  always_comb begin
    PM_ADDR = pc_q;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  chk_single_clock_ops: assert property (start && dec_cyc == CYC_1 |=> INSN_DONE && INSN_CYCLES == CYC_1) // RQ4
    else $error("one-clock instruction did not finish in one clock");
  chk_taken_extra: assert property (taken_now |=> st_q == ST_TAKEN ##1 INSN_DONE && BR_TAKEN) // RQ3
    else $error("taken branch did not add one clock");
  chk_not_taken: assert property (last && cond_q && !BR_COND |=> INSN_DONE && !BR_TAKEN) // RQ3
    else $error("untaken branch did not finish at base count");
  chk_cycle_total: assert property (INSN_DONE && !$past(start) |-> INSN_CYCLES == $past(base_q) + {3'h0, BR_TAKEN}) // RQ19
    else $error("clock count differs from opcode class");
  chk_rel_target: assert property (st_q == ST_TAKEN |=> pc_q == $past(pc_q) + {{8{last_q[7]}}, last_q}) // RQ17
    else $error("relative target wrong");
  chk_bytes_used: assert property (last |-> (capture ? idx_q + LEN_1 : idx_q) == len_q) // RQ5
    else $error("operand bytes not all consumed by final clock");
  chk_sfr_select: assert property (DIR_VALID |-> DIR_SFR == DIR_ADDR[7]) // RQ18
    else $error("direct address space select wrong");
  chk_halt_blocks: assert property (DBG_HALTED && !$past(DBG_STEP_REQ) && st_q == ST_FETCH |-> !start) // RQ14
    else $error("instruction started while halted");
  chk_access_parked: assert property (DBG_ACC_GNT |-> DBG_HALTED) // RQ15
    else $error("debug access granted while running");
  chk_idle_pc: assert property (st_q == ST_FETCH && !go |=> $stable(pc_q)) // RQ15
    else $error("program counter moved while parked");
endmodule

// >>> design/ctx_pkg.sv
// shared constants and types for the cycle-timed instruction sequencer
package ctx_pkg;
  // ==========================================================
  // widths and reset values
  localparam int PC_W = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SFR_BASE = 8'h80;
  // ==========================================================
  // flag update mask positions: carry, auxiliary carry, overflow
  localparam logic [2:0] FLG_CY = 3'h4;
  localparam logic [2:0] FLG_AC = 3'h2;
  localparam logic [2:0] FLG_OV = 3'h1;
  localparam logic [2:0] FLG_ARITH = 3'h7;
  localparam logic [2:0] FLG_MULDIV = 3'h5;
  // ==========================================================
  // instruction lengths and clock counts
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_5 = 4'h5;
  localparam logic [3:0] CYC_8 = 4'h8;
  localparam logic [3:0] CYC_TAKEN_EXTRA = 4'h1;
  // ==========================================================
  // how an instruction redirects the program counter
  typedef enum logic [2:0] {JK_NONE, JK_REL, JK_ABS11, JK_ABS16, JK_EXT} ctx_jump_t;
  // signed 8-bit offset added to the address after the instruction
  function automatic logic [15:0] ctx_rel_target(input logic [15:0] pc, input logic [7:0] rel);
    return pc + {{8{rel[7]}}, rel};
  endfunction
endpackage

// >>> design/ctx_op_decode.sv
// opcode class decoder: length, clock count, branch kind and flag effects
`timescale 1ns/1ns
module ctx_op_decode
  import ctx_pkg::*;
(
  input logic [7:0] op,
  output logic [1:0] len,
  output logic [3:0] cyc,
  output logic cond,
  output ctx_jump_t jump,
  output logic [2:0] flags,
  output logic has_dir
);
  logic [5:0] lc;
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = op[7:4];
  assign lo = op[3:0];
  assign len = lc[5:4];
  assign cyc = lc[3:0];
  // ==========================================================
  // classic encoding map, one column of the opcode table at a time
  always_comb begin // RQ1
    lc = {LEN_1, CYC_1};
    cond = 1'b0;
    jump = JK_NONE;
    flags = 3'h0;
    has_dir = 1'b0;
    case (lo)
      4'h0: begin
        case (hi)
          4'h0: lc = {LEN_1, CYC_1};
          4'h1, 4'h2, 4'h3: begin lc = {LEN_3, CYC_3}; cond = 1'b1; end // RQ3
          4'h4, 4'h5, 4'h6, 4'h7: begin lc = {LEN_2, CYC_2}; cond = 1'b1; end // RQ3
          4'h8: begin lc = {LEN_2, CYC_3}; jump = JK_REL; end
          4'h9: lc = {LEN_3, CYC_3};
          4'hA, 4'hB: begin lc = {LEN_2, CYC_2}; flags = FLG_CY; end
          4'hC, 4'hD: begin lc = {LEN_2, CYC_2}; has_dir = 1'b1; end
          default: lc = {LEN_1, CYC_3};
        endcase
      end
      4'h1: begin lc = {LEN_2, CYC_3}; jump = JK_ABS11; end
      4'h2: begin
        case (hi)
          4'h0, 4'h1: begin lc = {LEN_3, CYC_4}; jump = JK_ABS16; end
          4'h2, 4'h3: begin lc = {LEN_1, CYC_5}; jump = JK_EXT; end
          4'h4, 4'h5, 4'h6: begin lc = {LEN_2, CYC_2}; has_dir = 1'b1; end // RQ7
          4'h7, 4'h8, 4'hA: begin lc = {LEN_2, CYC_2}; flags = FLG_CY; end
          4'hE, 4'hF: lc = {LEN_1, CYC_3};
          default: lc = {LEN_2, CYC_2};
        endcase
      end
      4'h3: begin
        case (hi)
          4'h1, 4'h3, 4'hB, 4'hC, 4'hD: flags = FLG_CY; // RQ11
          4'h4, 4'h5, 4'h6: begin lc = {LEN_3, CYC_3}; has_dir = 1'b1; end // RQ8
          4'h7: begin lc = {LEN_1, CYC_3}; jump = JK_EXT; end
          4'h8, 4'h9, 4'hE, 4'hF: lc = {LEN_1, CYC_3};
          default: lc = {LEN_1, CYC_1}; // RQ11
        endcase
      end
      4'h4: begin
        case (hi)
          4'h8: begin lc = {LEN_1, CYC_8}; flags = FLG_MULDIV; end
          4'hA: begin lc = {LEN_1, CYC_4}; flags = FLG_MULDIV; end
          4'hB: begin lc = {LEN_3, CYC_3}; cond = 1'b1; flags = FLG_CY; end
          4'hD: flags = FLG_CY;
          4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: lc = {LEN_2, CYC_2}; // RQ5
          default: lc = {LEN_1, CYC_1}; // RQ11
        endcase
      end
      4'h5: begin
        has_dir = (hi != 4'hA);
        case (hi)
          4'h7, 4'h8: lc = {LEN_3, CYC_3}; // RQ9
          4'hA: lc = {LEN_1, CYC_1};
          4'hB: begin lc = {LEN_3, CYC_3}; cond = 1'b1; flags = FLG_CY; end
          4'hD: begin lc = {LEN_3, CYC_3}; cond = 1'b1; end
          default: lc = {LEN_2, CYC_2}; // RQ5
        endcase
      end
      4'h6, 4'h7: begin
        case (hi)
          4'h7: lc = {LEN_2, CYC_2};
          4'h8, 4'hA: begin lc = {LEN_2, CYC_2}; has_dir = 1'b1; end
          4'hB: begin lc = {LEN_3, CYC_4}; cond = 1'b1; flags = FLG_CY; end
          default: lc = {LEN_1, CYC_2}; // RQ6 RQ10
        endcase
      end
      default: begin
        case (hi)
          4'h7: lc = {LEN_2, CYC_2};
          4'h8, 4'hA: begin lc = {LEN_2, CYC_2}; has_dir = 1'b1; end // RQ12 RQ13
          4'hB: begin lc = {LEN_3, CYC_3}; cond = 1'b1; flags = FLG_CY; end
          4'hD: begin lc = {LEN_2, CYC_2}; cond = 1'b1; end
          default: lc = {LEN_1, CYC_1}; // RQ4
        endcase
      end
    endcase
    if (lo >= 4'h4 && (hi == 4'h2 || hi == 4'h3 || hi == 4'h9)) begin
      flags = FLG_ARITH;
    end
  end
endmodule

// >>> design/ctx_dbg_ctrl.sv
// run control for the debug host: halt, run, single step, breakpoint, access grant
`timescale 1ns/1ns
module ctx_dbg_ctrl
  import ctx_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic halt_req,
  input logic run_req,
  input logic step_req,
  input logic bp_en,
  input logic [15:0] bp_addr,
  input logic acc_req,
  input logic at_boundary,
  input logic [15:0] pc,
  input logic insn_start,
  output logic go,
  output logic halted_q,
  output logic acc_gnt_q
);
  logic step_pend_q;
  logic skip_bp_q;
  logic bp_hit;
  // ==========================================================
  // breakpoints only gate instruction start, so no user resource is touched
  assign bp_hit = at_boundary && bp_en && pc == bp_addr && !halted_q && !skip_bp_q; // RQ14 RQ15
  assign go = (!halted_q && !bp_hit) || step_pend_q; // RQ14
  // ==========================================================
  // halt and breakpoint win over a run request in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halted_q <= 1'b0;
    end else if (halt_req || bp_hit) begin
      halted_q <= 1'b1;
    end else if (run_req) begin
      halted_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_pend_q <= 1'b0;
      skip_bp_q <= 1'b0;
    end else begin
      if (insn_start) begin
        step_pend_q <= 1'b0;
      end else if (step_req && halted_q) begin
        step_pend_q <= 1'b1; // RQ14
      end
      if (insn_start) begin
        skip_bp_q <= 1'b0;
      end else if ((run_req || step_req) && halted_q) begin
        skip_bp_q <= 1'b1;
      end
    end
  end
  // register and memory access from the link only while the core is parked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_gnt_q <= 1'b0;
    end else begin
      // a run or step leaves the parked state, so the grant drops on the edge that samples the request, not a clock after
      acc_gnt_q <= acc_req && halted_q && !step_pend_q && !run_req && !step_req; // RQ15 RQ16
    end
  end
endmodule

// >>> tb/ctx_prog_mem.sv
// program memory model that feeds opcode and operand bytes to the sequencer
`timescale 1ns/1ns
module ctx_prog_mem (
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  // ==========================================================
  // storage
  logic [7:0] mem_q [0:65535];
  // unwritten space reads as a one-clock no-op, so a runaway core stays traceable
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_q[i] = 8'h00;
    end
  end
  // combinational read in the same cycle as the address
  assign data = mem_q[addr];
  task automatic put(input logic [15:0] a, input logic [7:0] b);
    mem_q[a] = b;
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the cycle-timed instruction sequencer
`timescale 1ns/1ns
module testbench
  import ctx_pkg::*;
;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] cyc;
    logic [1:0] len;
    logic tk;
    logic [2:0] flg;
    logic [7:0] dir;
    logic sfr;
    logic dv;
    logic [15:0] pc;
  } ctx_rec_t;
  logic clk_sys, rst, br_cond, dbg_halt_req, dbg_run_req, dbg_step_req, dbg_bp_en, dbg_acc_req;
  logic insn_start, insn_done, br_taken, dir_sfr, dir_valid, dbg_halted, dbg_acc_gnt;
  logic [15:0] pm_addr, ext_target, dbg_bp_addr;
  logic [7:0] pm_data, insn_opcode, dir_addr;
  logic [3:0] insn_cycles;
  logic [1:0] insn_bytes;
  logic [2:0] flag_mask;
  int n_errors = 0;
  int comparisons = 0;
  int n_done = 0;
  int n_start = 0;
  ctx_rec_t recs[$];
  // entry: opcode, length, clocks, flag mask shifted left by one with the direct-operand bit below
  localparam logic [19:0] TBL [0:22] = '{20'hE8110, 20'h2811E, 20'h2522F, 20'h2422E, 20'h2612E, 20'h06120,
    20'h16120, 20'h52221, 20'h53331, 20'h85331, 20'h75331, 20'hF6120, 20'hE4110, 20'hF4110, 20'h23110,
    20'h03110, 20'hC4110, 20'h33118, 20'h13118, 20'hA8221, 20'h88221, 20'hA5110, 20'h40220};
  // ==========================================================
  // design and program memory
  ctx_core_seq u_dut (.CLK_SYS(clk_sys), .RST(rst), .PM_ADDR(pm_addr), .PM_DATA(pm_data), .BR_COND(br_cond),
    .EXT_TARGET(ext_target), .INSN_OPCODE(insn_opcode), .INSN_START(insn_start), .INSN_DONE(insn_done),
    .INSN_CYCLES(insn_cycles), .INSN_BYTES(insn_bytes), .BR_TAKEN(br_taken), .FLAG_MASK(flag_mask),
    .DIR_ADDR(dir_addr), .DIR_SFR(dir_sfr), .DIR_VALID(dir_valid), .DBG_HALT_REQ(dbg_halt_req),
    .DBG_RUN_REQ(dbg_run_req), .DBG_STEP_REQ(dbg_step_req), .DBG_BP_EN(dbg_bp_en),
    .DBG_BP_ADDR(dbg_bp_addr), .DBG_ACC_REQ(dbg_acc_req), .DBG_HALTED(dbg_halted), .DBG_ACC_GNT(dbg_acc_gnt));
  ctx_prog_mem u_mem (.addr(pm_addr), .data(pm_data));
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // branch condition holds only in the loop region, so earlier branches fall through
  always @(posedge clk_sys) begin
    br_cond <= (pm_addr >= 16'h0300);
  end
  // done records sampled mid-cycle, clear of the launching edge
  always @(negedge clk_sys) begin
    if (rst === 1'h0 && insn_done === 1'h1) begin
      recs.push_back('{insn_opcode, insn_cycles, insn_bytes, br_taken, flag_mask, dir_addr, dir_sfr, dir_valid,
        pm_addr});
      n_done++;
    end
    if (rst === 1'h0 && insn_start === 1'h1) begin
      n_start++;
    end
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_recs(input int n);
    int k;
    k = 0;
    while (recs.size() < n && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
  endtask
  task automatic wait_halt(input logic v);
    int k;
    k = 0;
    while (dbg_halted !== v && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) dbg_halt_req <= 1'h1;
    else if (which == 1) dbg_step_req <= 1'h1;
    else dbg_run_req <= 1'h1;
    @(posedge clk_sys);
    dbg_halt_req <= 1'h0;
    dbg_step_req <= 1'h0;
    dbg_run_req <= 1'h0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] a;
    logic [19:0] e;
    @(posedge clk_sys);
    u_mem.put(16'h0000, 8'h02);
    u_mem.put(16'h0001, 8'h02);
    u_mem.put(16'h0002, 8'h00);
    a = 16'h0200;
    for (int i = 0; i < 23; i++) begin
      e = TBL[i];
      u_mem.put(a, e[19:12]);
      if (e[11:8] > 4'h1) u_mem.put(a + 16'h0001, i[0] ? 8'h80 : 8'h7F);
      if (e[11:8] > 4'h2) u_mem.put(a + 16'h0002, 8'h55);
      a = a + {12'h000, e[11:8]};
    end
    u_mem.put(16'h0300, 8'h40);
    u_mem.put(16'h0301, 8'h80);
    check(pm_addr, 16'h0000);
    check(dbg_halted, 1'h0);
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
  endtask
  task automatic t_timing();
    ctx_rec_t r;
    logic [19:0] e;
    wait_recs(24);
    r = recs.pop_front();
    check(r.op, 8'h02);
    check(r.cyc, CYC_4);
    check(r.pc, 16'h0200);
    for (int i = 0; i < 23; i++) begin
      e = TBL[i];
      r = recs.pop_front();
      check(r.op, e[19:12]);
      check(r.len, e[9:8]);
      check(r.cyc, e[7:4]);
      check(r.flg, e[3:1]);
      check(r.tk, 1'h0);
      if (e[0]) begin
        check(r.dv, 1'h1);
        check(r.dir, i[0] ? 8'h80 : 8'h7F);
        check(r.sfr, i[0]);
      end
    end
  endtask
  task automatic t_branch();
    ctx_rec_t r;
    int k;
    k = 0;
    r = '0;
    while (k < 400 && r.op !== 8'h40) begin
      if (recs.size() > 0) r = recs.pop_front();
      else begin
        @(posedge clk_sys);
        k++;
      end
    end
    check(r.cyc, CYC_3);
    check(r.len, LEN_2);
    check(r.tk, 1'h1);
    check(r.pc, 16'h0282);
  endtask
  task automatic t_halt_step();
    logic [15:0] pc;
    int d;
    int s;
    pulse(0);
    wait_halt(1'h1);
    check(dbg_halted, 1'h1);
    @(posedge clk_sys);
    dbg_acc_req <= 1'h1;
    // let an instruction already in flight finish before taking the snapshot
    repeat (6) @(negedge clk_sys);
    pc = pm_addr;
    d = n_done;
    s = n_start;
    repeat (10) @(negedge clk_sys);
    check(pm_addr, pc);
    check(n_done, d);
    check(n_start, s);
    check(dbg_acc_gnt, 1'h1);
    @(posedge clk_sys);
    dbg_acc_req <= 1'h0;
    pulse(1);
    repeat (20) @(negedge clk_sys);
    check(n_done, d + 1);
    check(n_start, s + 1);
    check(dbg_halted, 1'h1);
  endtask
  task automatic t_breakpoint();
    @(posedge clk_sys);
    dbg_bp_addr <= 16'h0300;
    dbg_bp_en <= 1'h1;
    pulse(2);
    wait_halt(1'h0);
    wait_halt(1'h1);
    check(dbg_halted, 1'h1);
    check(pm_addr, 16'h0300);
  endtask
  task automatic t_run_quiet();
    int d;
    @(posedge clk_sys);
    dbg_bp_en <= 1'h0;
    dbg_acc_req <= 1'h1;
    pulse(2);
    recs.delete();
    repeat (3) @(negedge clk_sys);
    d = 0;
    repeat (300) begin
      @(negedge clk_sys);
      if (dbg_acc_gnt !== 1'h0) d++;
    end
    check(d, 0);
    check(dbg_halted, 1'h0);
  endtask
  // ==========================================================
  // main sequence and verdict
  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    rst = 1'h1;
    br_cond = 1'h0;
    ext_target = 16'h0000;
    dbg_halt_req = 1'h0;
    dbg_run_req = 1'h0;
    dbg_step_req = 1'h0;
    dbg_bp_en = 1'h0;
    dbg_bp_addr = 16'h0000;
    dbg_acc_req = 1'h0;
    t_reset();
    t_timing();
    t_branch();
    t_halt_step();
    t_breakpoint();
    t_run_quiet();
    // a debug access held during the run must not change branch timing
    t_branch();
    end_of_test();
  end
  // the whole sequence needs about 750 clocks
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
endmodule
